// ---- core/uvwff_commutate.sv ----
module uvwff_commutate
    import uvwff_pkg::*;
(
    input wire logic clock_in, // 125 MHz
    input wire logic rst_b_in, // Sync reset, active low
    input wire logic [15:0] angle_in, // Shaft angle
    input wire logic [2:0] pole_pair_select_in, // Pole pairs minus one
    output logic [2:0] phase_out // Phase outputs, W V U
);
    function automatic logic [2:0] sector_of(input logic [15:0] ang);
        logic [18:0] prod;
        prod = 19'(ang) * 19'(SECTORS);
        sector_of = prod[18:16];
    endfunction

    logic [2:0] sector;
    logic [18:0] elec_prod;
    wire [15:0] elec;
    wire [2:0] sec_mid;
    wire [2:0] sec_up;
    wire [2:0] sec_dn;
    wire hold;
    wire [2:0] next_sector;

    // Each pole pair walks one electrical turn
    assign elec_prod = 19'(angle_in) * 19'({1'b0, pole_pair_select_in} + 4'h1);
    assign elec = elec_prod[15:0];
    assign sec_mid = sector_of(elec);
    assign sec_up = sector_of(elec + COMM_HYST);
    assign sec_dn = sector_of(elec - COMM_HYST);
    // Keep the old state until the angle is clear of the boundary
    assign hold = (sector == sec_up) || (sector == sec_dn);
    assign next_sector = hold ? sector : sec_mid;

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            sector <= 3'h0;
            phase_out <= 3'h0;
        end else begin
            sector <= next_sector;
            // Three sectors high each, shifted one sector apart
            phase_out[0] <= (next_sector <= 3'h2);
            phase_out[1] <= (next_sector >= 3'h1) && (next_sector <= 3'h3);
            phase_out[2] <= (next_sector >= 3'h2) && (next_sector <= 3'h4);
        end
    end
endmodule

// ---- core/uvwff_pkg.sv ----
package uvwff_pkg;
    // Serial frame layout: command, register address, value
    localparam int FRAME_W = 16;
    localparam int CMD_MSB = 15;
    localparam int CMD_LSB = 13;
    localparam int ADDR_MSB = 12;
    localparam int ADDR_LSB = 8;
    localparam logic [2:0] CMD_READ = 3'h2;
    localparam logic [2:0] CMD_WRITE = 3'h4;

    // Register offsets
    localparam logic [4:0] THRESH_CFG_ADDR = 5'h06;
    localparam logic [4:0] POLE_CFG_ADDR = 5'h07;
    localparam logic [4:0] FIELD_ALARM_STATUS_ADDR = 5'h1B;

    // Field positions
    localparam int LOW_THR_LSB = 5;
    localparam int HIGH_THR_LSB = 2;
    localparam int POLE_SEL_LSB = 0;
    localparam int STAT_HIGH_BIT = 7;
    localparam int STAT_LOW_BIT = 6;
    localparam int STAT_SAMPLE_A_BIT = 3;
    localparam int STAT_SAMPLE_B_BIT = 2;

    // Reset values
    localparam logic [7:0] THRESH_CFG_RESET = 8'h1C;
    localparam logic [7:0] POLE_CFG_RESET = 8'h00;

    // Timing at 125 MHz
    localparam int CLK_PERIOD_PS = 8000;
    localparam int GLITCH_PS = 1400000;
    localparam int GLITCH_CYC = GLITCH_PS / CLK_PERIOD_PS;
    localparam int SAMPLE_GAP_PS = 2000000;
    localparam int SAMPLE_GAP_CYC =
        (SAMPLE_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int GLITCH_SPACING_PS = 100000000;
    localparam int GLITCH_SPACING_CYC =
        (GLITCH_SPACING_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Angle scale: 16-bit full turn, figures in tenths of a degree
    localparam int ANGLE_W = 16;
    localparam int FULL_TURN = 65536;
    localparam int GLITCH_HALF_WIN = 15 * FULL_TURN / 3600;
    localparam int GLITCH_CENTER_0 = 440 * FULL_TURN / 3600;
    localparam int GLITCH_CENTER_1 = 1380 * FULL_TURN / 3600;
    localparam int GLITCH_CENTER_2 = 2240 * FULL_TURN / 3600;
    localparam int GLITCH_CENTER_3 = 3180 * FULL_TURN / 3600;
    // Electrical-angle hysteresis, above the angle noise floor
    localparam logic [15:0] COMM_HYST = 16'h0100;
    localparam int SECTORS = 6;

    // Field threshold in mT for rising field; falling is 6 mT lower
    localparam logic [7:0] FIELD_HYST_MT = 8'h06;
    function automatic logic [7:0] thr_rise(input logic [2:0] code);
        unique case (code)
            3'h0: thr_rise = 8'h1A;
            3'h1: thr_rise = 8'h29;
            3'h2: thr_rise = 8'h38;
            3'h3: thr_rise = 8'h46;
            3'h4: thr_rise = 8'h54;
            3'h5: thr_rise = 8'h62;
            3'h6: thr_rise = 8'h70;
            3'h7: thr_rise = 8'h7E;
        endcase
    endfunction
endpackage

// ---- core/uvwff_top.sv ----
module uvwff_top
    import uvwff_pkg::*;
#(
    parameter int GLITCH_SPACING = GLITCH_SPACING_CYC,
    parameter bit GLITCH_ENABLE = 1'b1
) (
    input wire logic clock_in, // 125 MHz
    input wire logic rst_b_in, // Sync reset, active low
    input wire logic [15:0] angle_in, // Shaft angle, full turn
    input wire logic [7:0] field_mt_in, // Field strength in mT
    input wire logic frame_valid_in, // One-cycle frame strobe
    input wire logic [15:0] frame_in, // Received frame
    output logic [15:0] reply_out, // Word for next transmission
    output logic field_low_flag_out, // Low-field alarm pin
    output logic field_high_flag_out, // High-field alarm pin
    output logic [2:0] commutation_phase_outputs_out // Phases W V U
);
    // Counter is 16 bits and must outlast one pulse
    localparam bit SPACING_OK =
        GLITCH_SPACING > GLITCH_CYC && GLITCH_SPACING <= 65535;
    if (!SPACING_OK) begin : g_bad_spacing
        $error("GLITCH_SPACING out of range");
    end

    logic [7:0] thresh_cfg;
    logic [7:0] pole_cfg;
    logic low_state;
    logic high_state;
    logic [7:0] glitch_cnt;
    logic [15:0] spacing_cnt;
    logic [15:0] lfsr;
    logic [7:0] gap_cnt;
    logic low_prev;
    logic [2:0] phases;

    wire [2:0] cmd = frame_in[CMD_MSB:CMD_LSB];
    wire [4:0] addr = frame_in[ADDR_MSB:ADDR_LSB];
    wire [2:0] low_thr = thresh_cfg[LOW_THR_LSB +: 3];
    wire [2:0] high_thr = thresh_cfg[HIGH_THR_LSB +: 3];
    wire [7:0] low_rise = thr_rise(low_thr);
    wire [7:0] low_fall = low_rise - FIELD_HYST_MT;
    wire [7:0] high_rise = thr_rise(high_thr);
    wire [7:0] high_fall = high_rise - FIELD_HYST_MT;

    // Each flag has its own comparator, so any code pair is legal
    wire next_low = low_state ? (field_mt_in < low_rise)
                              : (field_mt_in < low_fall);
    wire next_high = high_state ? (field_mt_in >= high_fall)
                                : (field_mt_in >= high_rise);

    function automatic logic near(input logic [15:0] a, input int c);
        logic [15:0] d;
        d = a - 16'(c);
        near = (d <= 16'(GLITCH_HALF_WIN)) ||
               (d >= 16'(FULL_TURN - GLITCH_HALF_WIN));
    endfunction

    localparam int CENTERS [4] = '{GLITCH_CENTER_0, GLITCH_CENTER_1,
                                   GLITCH_CENTER_2, GLITCH_CENTER_3};
    logic [3:0] win_hit;

    // Four separate windows, one comparator each
    for (genvar w = 0; w < 4; w++) begin : g_win
        assign win_hit[w] = near(angle_in, CENTERS[w]);
    end
    wire in_window = |win_hit;
    wire glitch_on = (glitch_cnt != 8'h00);
    // Random firing, throttled by the spacing counter
    wire glitch_fire = GLITCH_ENABLE && in_window && !glitch_on &&
                       (spacing_cnt == 16'h0000) &&
                       (lfsr[3:0] == 4'hF);
    wire low_pin = low_state || glitch_on;
    wire gap_done = (gap_cnt == 8'(SAMPLE_GAP_CYC - 1));

    // Samples are active low: A is live low_pin, B is low_pin latched at the last gap end
    wire [7:0] status = {high_state, low_pin, 2'b00,
                         ~low_pin, ~low_prev, 2'b00};

    wire is_read = frame_valid_in && (cmd == CMD_READ);
    wire is_write = frame_valid_in && (cmd == CMD_WRITE);
    wire [7:0] rd_data = (addr == THRESH_CFG_ADDR) ? thresh_cfg :
                         (addr == POLE_CFG_ADDR) ? pole_cfg :
                         (addr == FIELD_ALARM_STATUS_ADDR) ? status :
                         8'h00;

    uvwff_commutate u_comm (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .angle_in(angle_in),
        .pole_pair_select_in(pole_cfg[POLE_SEL_LSB +: 3]),
        .phase_out(phases)
    );
    assign commutation_phase_outputs_out = phases;

    wire thr_wr = is_write && (addr == THRESH_CFG_ADDR);
    wire pole_wr = is_write && (addr == POLE_CFG_ADDR);

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            thresh_cfg <= THRESH_CFG_RESET;
        end else if (thr_wr) begin
            thresh_cfg <= frame_in[7:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            pole_cfg <= POLE_CFG_RESET;
        end else if (pole_wr) begin
            pole_cfg <= frame_in[7:0];
        end
    end

    wire [15:0] next_reply = is_read ? {8'h00, rd_data} :
                             frame_valid_in ? 16'h0000 : reply_out;

    // Loaded at the command frame, shifted out during the next one
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            reply_out <= 16'h0000;
        end else begin
            reply_out <= next_reply;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            low_state <= 1'b0;
            high_state <= 1'b0;
        end else begin
            low_state <= next_low;
            high_state <= next_high;
        end
    end

    // Pins are a plain register stage behind low_pin (low flag or glitch) and high_state
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            field_low_flag_out <= 1'b0;
            field_high_flag_out <= 1'b0;
        end else begin
            field_low_flag_out <= low_pin;
            field_high_flag_out <= high_state;
        end
    end

    wire lfsr_fb = lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10];
    wire [15:0] next_lfsr = {lfsr[14:0], lfsr_fb};
    wire [7:0] next_glitch_cnt = glitch_fire ? 8'(GLITCH_CYC) :
                                 glitch_on ? glitch_cnt - 8'h01 :
                                 glitch_cnt;
    wire spacing_busy = (spacing_cnt != 16'h0000);
    // Reloaded at each pulse start, so starts keep the minimum spacing
    wire [15:0] next_spacing_cnt =
        glitch_fire ? 16'(GLITCH_SPACING - 1) :
        spacing_busy ? spacing_cnt - 16'h0001 : spacing_cnt;

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            lfsr <= 16'hACE1;
        end else begin
            lfsr <= next_lfsr;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            glitch_cnt <= 8'h00;
        end else begin
            glitch_cnt <= next_glitch_cnt;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            spacing_cnt <= 16'h0000;
        end else begin
            spacing_cnt <= next_spacing_cnt;
        end
    end

    wire [7:0] next_gap_cnt = gap_done ? 8'h00 : gap_cnt + 8'h01;
    wire next_low_prev = gap_done ? low_pin : low_prev;

    // A glitch is shorter than the gap, so low_prev latches it at one gap end only
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            gap_cnt <= 8'h00;
        end else begin
            gap_cnt <= next_gap_cnt;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            low_prev <= 1'b0;
        end else begin
            low_prev <= next_low_prev;
        end
    end
endmodule

// ---- sim/tb_top.sv ----
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin \
    n_fail++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import uvwff_pkg::*;
    logic clock_in = 1'b0, rst_b_in = 1'b0;
    logic [15:0] angle_in = 16'h0000;
    logic [7:0] field_mt_in = 8'h3C;
    wire fv, lo, hi;
    wire [15:0] fr, reply;
    wire [2:0] ph;
    int n_fail = 0, compares = 0, s = 0, pn = 0, lc = 0, hc = 7, run = 0;
    int rise[8] = '{26, 41, 56, 70, 84, 98, 112, 126};
    int ctr[4] = '{8010, 25122, 40777, 57889};
    int edge_a[4] = '{1350, 1380, 1350, 1420};
    bit [31:0] lfsr = 83977;
    bit flo = 0, fhi = 0, pl = 1;
    int np = 0;
    logic [7:0] d;
    logic f;
    always #4 clock_in = ~clock_in;
    uvwff_top #(.GLITCH_SPACING(600)) i_dut(.clock_in, .rst_b_in,
        .angle_in, .field_mt_in, .frame_valid_in(fv), .frame_in(fr),
        .reply_out(reply), .field_low_flag_out(lo),
        .field_high_flag_out(hi), .commutation_phase_outputs_out(ph));
    uvwff_host i_host(.clock_in, .low_in(lo), .frame_valid_out(fv),
        .frame_out(fr));
    function bit [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function int sec(int e);
        return (e & 32'hFFFF) * 6 / 65536;
    endfunction
    task upd(); // Sector moves only once clear of the hysteresis band
        int e;
        e = (int'(angle_in) * (pn + 1)) & 32'hFFFF;
        if (sec(e + 256) != s && sec(e - 256) != s) s = sec(e);
    endtask
    task fupd();
        if (field_mt_in < rise[lc] - 6) flo = 1;
        else if (field_mt_in >= rise[lc]) flo = 0;
        if (field_mt_in >= rise[hc]) fhi = 1;
        else if (field_mt_in < rise[hc] - 6) fhi = 0;
    endtask
    task rd(input logic [4:0] a);
        i_host.send(CMD_READ, a, 8'h00);
        d = reply[7:0];
        `CHK("reply_top", 8'h00, reply[15:8])
    endtask
    task give_verdict();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clock_in);
        rst_b_in = 1'b1;
        rd(THRESH_CFG_ADDR); `CHK("reg6", THRESH_CFG_RESET, d)
        rd(POLE_CFG_ADDR); `CHK("reg7", POLE_CFG_RESET, d)
        rd(5'h09); `CHK("unmapped", 8'h00, d)
        i_host.send(CMD_WRITE, THRESH_CFG_ADDR, 8'hA8);
        lc = 5;
        hc = 2;
        @(negedge clock_in);
        fupd();
        repeat (40) begin
            field_mt_in = 8'(rnd() % 141);
            fupd();
            repeat (3) @(negedge clock_in);
            `CHK("low_pin", flo, lo)
            `CHK("high_pin", fhi, hi)
        end
        $display("test flags done");
        foreach (ctr[i]) begin
            field_mt_in = 8'h00 - 8'(i % 2);
            repeat (600) @(negedge clock_in);
            rd(FIELD_ALARM_STATUS_ADDR);
            `CHK("status_flags", (i % 2) ? 2'h2 : 2'h1, d[7:6])
            `CHK("corrected", !(i % 2), !(d[3] | d[2]))
            `CHK("pin_low", !(i % 2), lo)
            `CHK("inv_high", !hi, lo)
        end
        foreach (ctr[i]) begin
            angle_in = 16'(ctr[i]);
            upd();
            pl = 1'b1;
            repeat (1500) begin
                @(negedge clock_in);
                // Count only pulses whose start falls in this window
                if (lo && (run > 0 || !pl)) run++;
                else if (!lo && run > 0) begin
                    `CHK("pulse_len", 175, run)
                    np++;
                    run = 0;
                end
                pl = lo;
            end
            run = 0;
            i_host.dbl_sample(f);
            `CHK("filtered", 1'b0, f)
        end
        `CHK("pulse_seen", 1'b1, np > 0)
        angle_in = 16'h0000;
        upd();
        // A pulse begun just before the move must run out first
        repeat (200) @(negedge clock_in);
        repeat (1000) begin
            @(negedge clock_in);
            `CHK("no_pulse", 1'b0, lo)
        end
        $display("test pulses done");
        field_mt_in = 8'h3C;
        for (int n = 0; n < 8; n++) begin
            i_host.send(CMD_WRITE, POLE_CFG_ADDR, 8'(n));
            pn = n;
            @(negedge clock_in);
            upd();
            rd(POLE_CFG_ADDR); `CHK("reg7", 8'(n), d)
            for (int k = 0; k < 16; k++) begin
                angle_in = (n == 7 && k < 4) ? 16'(edge_a[k]) : 16'(rnd());
                upd();
                repeat (2) @(negedge clock_in);
                `CHK("phases", {s > 1 && s < 5, s > 0 && s < 4, s < 3}, ph)
            end
        end
        $display("test phases done");
        give_verdict();
    end
endmodule

// ---- sim/uvwff_host.sv ----
module uvwff_host
    import uvwff_pkg::*;
(
    input wire logic clock_in, // Bench clock
    input wire logic low_in, // Low alarm pin
    output logic frame_valid_out, // Frame strobe
    output logic [15:0] frame_out // Frame word
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        frame_valid_out = 1'b0;
        frame_out = 16'hA5C3;
    end
    task send(input logic [2:0] c, input logic [4:0] a, input logic [7:0] v);
        @(negedge clock_in);
        frame_valid_out <= 1'b1;
        frame_out <= {c, a, v};
        @(negedge clock_in);
        frame_valid_out <= 1'b0;
        frame_out <= ~{c, a, v}; // Stale word would hide a strobe bug
    endtask
    // 300 cycles is 2.4 us: longer than any pulse, short of the spacing
    task dbl_sample(output logic f);
        f = low_in;
        repeat (300) @(negedge clock_in);
        f = f & low_in;
    endtask
endmodule

// ---- sim/uvwff_top_sva.sv ----
module uvwff_top_sva
    import uvwff_pkg::*;
(
    input wire logic clock_in, // Clock
    input wire logic rst_b_in, // Reset
    input wire logic [15:0] angle_in, // Angle
    input wire logic [7:0] field_mt_in, // Field
    input wire logic frame_valid_in, // Strobe
    input wire logic [15:0] frame_in, // Frame
    input wire logic [15:0] reply_out, // Reply
    input wire logic field_low_flag_out, // Low pin
    input wire logic field_high_flag_out, // High pin
    input wire logic [2:0] commutation_phase_outputs_out // Phases
);
    function automatic bit in_win(input int a, input int c);
        return a >= c - GLITCH_HALF_WIN && a <= c + GLITCH_HALF_WIN;
    endfunction
    wire near_w = in_win(angle_in, GLITCH_CENTER_0) ||
        in_win(angle_in, GLITCH_CENTER_1) ||
        in_win(angle_in, GLITCH_CENTER_2) ||
        in_win(angle_in, GLITCH_CENTER_3);
    wire rd_w = frame_valid_in && frame_in[15:13] == CMD_READ;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    property p_rst;
        $rose(rst_b_in) |-> reply_out == 16'h0000 && !field_low_flag_out
            && !field_high_flag_out && commutation_phase_outputs_out == 3'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_nonread;
        frame_valid_in && !rd_w |=> reply_out == 16'h0000;
    endproperty
    a_nonread: assert property (p_nonread) else $error("reply");
    property p_hold;
        !frame_valid_in |=> $stable(reply_out);
    endproperty
    a_hold: assert property (p_hold) else $error("reply moved");
    property p_high;
        (field_mt_in == 8'hFF) [*3] |=> field_high_flag_out;
    endproperty
    a_high: assert property (p_high) else $error("high flag");
    property p_low;
        (field_mt_in == 8'h00) [*3] |=> field_low_flag_out
            && !field_high_flag_out;
    endproperty
    a_low: assert property (p_low) else $error("low flag");
    property p_where;
        $rose(field_low_flag_out) && $past(field_mt_in, 2) == 8'hFF
            && $past(field_mt_in, 3) == 8'hFF
            |-> $past(near_w) || $past(near_w, 2) || $past(near_w, 3);
    endproperty
    a_where: assert property (p_where) else $error("pulse angle");
    property p_legal;
        commutation_phase_outputs_out != 3'h2
            && commutation_phase_outputs_out != 3'h5;
    endproperty
    a_legal: assert property (p_legal) else $error("phase code");
    property p_steady;
        ($stable(angle_in) && !frame_valid_in) [*4]
            |=> $stable(commutation_phase_outputs_out);
    endproperty
    a_steady: assert property (p_steady) else $error("phase toggle");
    c_pulse: cover property ($rose(field_low_flag_out) && near_w);
    c_read: cover property (rd_w);
    c_phase: cover property ($changed(commutation_phase_outputs_out));
endmodule
bind uvwff_top uvwff_top_sva i_sva(.clock_in, .rst_b_in, .angle_in,
    .field_mt_in, .frame_valid_in, .frame_in, .reply_out,
    .field_low_flag_out, .field_high_flag_out,
    .commutation_phase_outputs_out);
